// file: rtl/cpu_interrupt_and_status_unit.sv
// Interrupt arbitration, entry and return sequencing, stack pointer, flags and change guard.
`include "irq_unit_params.svh"
`default_nettype none

module cpu_interrupt_and_status_unit #(
    parameter int              NUM_SRC     = 8,
    parameter logic [7:0]      LEVEL_MASK  = 8'h00,
    parameter int              PC_W        = 11,
    parameter logic [15:0]     top_of_sram = 16'h013F
) (
    // Clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    reset_in,
    // I/O register port
    input  wire logic [5:0]              io_addr_in,
    input  wire logic                    io_wr_in,
    input  wire logic                    io_rd_in,
    input  wire irq_unit_pkg::byte_t     io_wdata_in,
    output var  irq_unit_pkg::byte_t     io_rdata_out,
    // Interrupt sources
    input  wire logic [NUM_SRC-1:0]      src_event_in,
    input  wire logic [NUM_SRC-1:0]      src_level_in,
    // Instruction sequencer
    input  wire logic                    instr_done_in,
    input  wire logic                    global_irq_set_op_in,
    input  wire logic                    global_irq_clear_op_in,
    input  wire logic                    return_from_irq_op_in,
    input  wire logic                    sleeping_in,
    input  wire logic [PC_W-1:0]         pc_in,
    input  wire logic                    call_push_in,
    input  wire logic                    ret_pop_in,
    input  wire logic                    byte_push_in,
    input  wire logic                    byte_pop_in,
    input  wire logic                    alu_flags_we_in,
    input  wire logic [6:0]              alu_flags_in,
    output logic                         irq_ack_out,
    output logic                         seq_busy_out,
    output logic                         pc_load_out,
    output logic [PC_W-1:0]              pc_value_out,
    // Stack memory port
    output logic                         mem_wr_out,
    output logic                         mem_rd_out,
    output logic [15:0]                  mem_addr_out,
    output irq_unit_pkg::byte_t          mem_wdata_out,
    input  wire irq_unit_pkg::byte_t     mem_rdata_in,
    // Status to the rest of the core
    output logic                         protected_write_ok_out,
    output irq_unit_pkg::byte_t          core_flags_out,
    output logic [15:0]                  stack_pointer_out
);
    import irq_unit_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    seq_state_e           state;
    logic [3:0]           cnt;
    logic [3:0]           limit;
    logic [2:0]           sel_index;
    logic [PC_W-1:0]      ret_addr;
    byte_t                ret_high;
    byte_t                core_flags;
    logic [15:0]          stack_pointer;
    byte_t                irq_flags;
    byte_t                irq_enable;
    logic                 guard_open;
    logic [2:0]           guard_count;

    // Lowest set index; index i is vector i+1 since vector zero is reset.
    function automatic logic [3:0] first_set(input logic [7:0] vec);
        logic [3:0] res;
        res = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (vec[i]) begin
                res = 4'(i);
            end
        end
        return res;
    endfunction : first_set

    // ----------------------------------------------------------------
    // Decode and arbitration
    // ----------------------------------------------------------------
    wire logic [7:0] src_event = 8'(src_event_in);
    wire logic [7:0] src_level = 8'(src_level_in);
    wire logic       io_write  = io_wr_in;
    wire logic       wr_flags  = io_write && io_addr_in == `FLAGS_ADDR;
    wire logic       wr_iflag  = io_write && io_addr_in == `IRQ_FLAG_ADDR;
    wire logic       wr_ien    = io_write && io_addr_in == `IRQ_ENABLE_ADDR;
    wire logic       wr_spl    = io_write && io_addr_in == `SP_LOW_ADDR;
    wire logic       wr_guard  = io_write && io_addr_in == `GUARD_ADDR;
    wire logic       gie       = core_flags[`FLAG_GIE];
    // Level sources bypass the flag latch and vanish with their condition.
    wire logic [7:0] pending   = (irq_flags & ~LEVEL_MASK) | (src_level & LEVEL_MASK);
    wire logic [7:0] requests  = pending & irq_enable;
    wire logic [3:0] winner    = first_set(requests);
    // Clear-enable in the same cycle already blocks; done marks the end of any
    // multi-cycle instruction, so entry never splits one.
    wire logic       take      = state == SEQ_IDLE && instr_done_in && gie
                                 && !global_irq_clear_op_in && !guard_open
                                 && !winner[3];
    wire logic       vectoring = state == SEQ_ENTRY && cnt == limit - 4'h1;
    wire logic       returning = state == SEQ_RETURN && cnt == `RETURN_CYCLES - 4'h1;
    wire logic [7:0] hw_clear  = vectoring ? (8'h01 << sel_index) : 8'h00;
    wire logic [7:0] sw_clear  = wr_iflag ? io_wdata_in : 8'h00;
    // A new event wins over a clear arriving in the same cycle.
    wire logic [7:0] next_irq_flags = (irq_flags & ~(hw_clear | sw_clear))
                                      | (src_event & ~LEVEL_MASK);
    wire logic       alu_sign  = alu_flags_in[`FLAG_N] ^ alu_flags_in[`FLAG_V];
    wire logic       io_sign   = io_wdata_in[`FLAG_N] ^ io_wdata_in[`FLAG_V];
    // Opens on the signature and closes with the fourth completed instruction.
    wire logic       next_guard_open = (wr_guard && io_wdata_in == `GUARD_SIGNATURE)
                                       || (guard_open && !(instr_done_in
                                           && guard_count == `GUARD_WINDOW_INSTR - 3'h1));

    // ----------------------------------------------------------------
    // Flags register
    // ----------------------------------------------------------------
    // Entry and return touch only the enable bit; software saves the rest.
    byte_t next_core_flags;
    always_comb begin
        next_core_flags = core_flags;
        if (wr_flags) begin
            next_core_flags = io_wdata_in;
            next_core_flags[`FLAG_S] = io_sign;
        end
        if (alu_flags_we_in) begin
            next_core_flags[6:0] = alu_flags_in;
            next_core_flags[`FLAG_S] = alu_sign;
        end
        if (global_irq_set_op_in) begin
            next_core_flags[`FLAG_GIE] = 1'b1;
        end
        if (global_irq_clear_op_in) begin
            next_core_flags[`FLAG_GIE] = 1'b0;
        end
        if (take) begin
            next_core_flags[`FLAG_GIE] = 1'b0;
        end
        if (returning) begin
            next_core_flags[`FLAG_GIE] = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            core_flags <= `FLAGS_RESET;
            irq_flags  <= `IRQ_REG_RESET;
            irq_enable <= `IRQ_REG_RESET;
        end else begin
            core_flags <= next_core_flags;
            irq_flags  <= next_irq_flags;
            if (wr_ien) begin
                irq_enable <= io_wdata_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Stack pointer
    // ----------------------------------------------------------------
    logic [15:0] next_stack_pointer;
    always_comb begin
        next_stack_pointer = stack_pointer;
        if (wr_spl) begin
            next_stack_pointer = {stack_pointer[15:8], io_wdata_in};
        end
        if (byte_push_in) begin
            next_stack_pointer = stack_pointer - 16'h0001;
        end
        if (byte_pop_in) begin
            next_stack_pointer = stack_pointer + 16'h0001;
        end
        if (call_push_in) begin
            next_stack_pointer = stack_pointer - 16'h0002;
        end
        if (ret_pop_in) begin
            next_stack_pointer = stack_pointer + 16'h0002;
        end
        if (state == SEQ_ENTRY && cnt == limit - 4'h3) begin
            next_stack_pointer = stack_pointer - 16'h0002;
        end
        if (returning) begin
            next_stack_pointer = stack_pointer + 16'h0002;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            stack_pointer <= top_of_sram;
        end else begin
            stack_pointer <= next_stack_pointer;
        end
    end

    // ----------------------------------------------------------------
    // Change guard
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            guard_open  <= 1'b0;
            guard_count <= 3'h0;
        end else if (wr_guard && io_wdata_in == `GUARD_SIGNATURE) begin
            guard_open  <= 1'b1;
            guard_count <= 3'h0;
        end else if (guard_open && instr_done_in) begin
            guard_count <= guard_count + 3'h1;
            if (guard_count == `GUARD_WINDOW_INSTR - 3'h1) begin
                guard_open <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Entry and return sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state     <= SEQ_IDLE;
            cnt       <= 4'h0;
            limit     <= `ENTRY_CYCLES;
            sel_index <= 3'h0;
            ret_addr  <= '0;
            ret_high  <= 8'h00;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    cnt <= 4'h0;
                    if (take) begin
                        state     <= SEQ_ENTRY;
                        sel_index <= winner[2:0];
                        ret_addr  <= pc_in;
                        limit     <= sleeping_in ? `ENTRY_CYCLES + `SLEEP_EXTRA_CYCLES
                                                 : `ENTRY_CYCLES;
                    end else if (return_from_irq_op_in) begin
                        state <= SEQ_RETURN;
                    end
                end
                SEQ_ENTRY: begin
                    cnt <= cnt + 4'h1;
                    if (vectoring) begin
                        state <= SEQ_IDLE;
                    end
                end
                SEQ_RETURN: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'h2) begin
                        ret_high <= mem_rdata_in;
                    end
                    // Back to idle without blocking: the next take needs a fresh
                    // instruction completion, so one main instruction always runs.
                    if (returning) begin
                        state <= SEQ_IDLE;
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    wire logic push_low  = state == SEQ_ENTRY && cnt == limit - 4'h4;
    wire logic push_high = state == SEQ_ENTRY && cnt == limit - 4'h3;
    wire logic pop_high  = state == SEQ_RETURN && cnt == 4'h0;
    wire logic pop_low   = state == SEQ_RETURN && cnt == 4'h1;
    byte_t     read_mux;
    assign read_mux = io_addr_in == `FLAGS_ADDR      ? core_flags :
                      io_addr_in == `SP_LOW_ADDR     ? stack_pointer[7:0] :
                      io_addr_in == `SP_HIGH_ADDR    ? stack_pointer[15:8] :
                      io_addr_in == `GUARD_ADDR      ? {7'h00, guard_open} :
                      io_addr_in == `IRQ_FLAG_ADDR   ? irq_flags :
                      io_addr_in == `IRQ_ENABLE_ADDR ? irq_enable : 8'h00;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            io_rdata_out           <= 8'h00;
            irq_ack_out            <= 1'b0;
            seq_busy_out           <= 1'b0;
            pc_load_out            <= 1'b0;
            pc_value_out           <= '0;
            mem_wr_out             <= 1'b0;
            mem_rd_out             <= 1'b0;
            mem_addr_out           <= 16'h0000;
            mem_wdata_out          <= 8'h00;
            protected_write_ok_out <= 1'b0;
            core_flags_out         <= `FLAGS_RESET;
            stack_pointer_out      <= top_of_sram;
        end else begin
            io_rdata_out           <= io_rd_in ? read_mux : 8'h00;
            irq_ack_out            <= take;
            seq_busy_out           <= take || return_from_irq_op_in
                                      || (state != SEQ_IDLE && !vectoring && !returning);
            pc_load_out            <= vectoring || returning;
            pc_value_out           <= vectoring ? PC_W'({1'b0, sel_index} + 4'h1)
                                               : PC_W'({ret_high, mem_rdata_in});
            mem_wr_out             <= push_low || push_high;
            mem_rd_out             <= pop_high || pop_low;
            mem_addr_out           <= push_low  ? stack_pointer :
                                      push_high ? stack_pointer - 16'h0001 :
                                      pop_high  ? stack_pointer + 16'h0001 :
                                                  stack_pointer + 16'h0002;
            mem_wdata_out          <= push_low ? ret_addr[7:0] : 8'(ret_addr >> 8);
            protected_write_ok_out <= next_guard_open;
            core_flags_out         <= next_core_flags;
            stack_pointer_out      <= next_stack_pointer;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    AST_TAKE_NEEDS_GIE: assert property (take |-> gie && irq_enable[winner[2:0]])
        else $error("Interrupt taken without both enables.");
    AST_TAKE_CLEARS_GIE: assert property (take |=> !core_flags[`FLAG_GIE])
        else $error("Global enable not cleared on entry.");
    AST_RETURN_SETS_GIE: assert property (returning |=> core_flags[`FLAG_GIE])
        else $error("Global enable not set on return.");
    AST_CLI_BLOCKS: assert property (global_irq_clear_op_in |-> !take)
        else $error("Interrupt taken alongside clear-enable.");
    AST_ENTRY_LENGTH: assert property (take && !sleeping_in |=> ##4 pc_load_out)
        else $error("Entry did not load the vector after four cycles.");
    AST_SLEEP_ENTRY: assert property (take && sleeping_in |=> !pc_load_out [*8] ##1 pc_load_out)
        else $error("Wake entry not eight cycles.");
    AST_RETURN_LENGTH: assert property (state == SEQ_IDLE && return_from_irq_op_in && !take
        |=> ##4 pc_load_out && stack_pointer == $past(stack_pointer, 4) + 16'h0002)
        else $error("Return timing or stack adjust wrong.");
    AST_GUARD_BLOCKS: assert property (guard_open |-> !take)
        else $error("Interrupt taken inside guard window.");
    AST_GUARD_READ: assert property (io_rd_in && io_addr_in == `GUARD_ADDR
        |=> io_rdata_out[7:1] == 7'h00 && io_rdata_out[0] == $past(guard_open))
        else $error("Guard read value wrong.");
    AST_SIGN_BIT: assert property (core_flags[`FLAG_S]
        == (core_flags[`FLAG_N] ^ core_flags[`FLAG_V]))
        else $error("Sign flag differs from N xor V.");
    AST_FLAG_CLEARED: assert property (vectoring && !src_event[sel_index]
        |=> !irq_flags[sel_index])
        else $error("Served flag not cleared.");
    AST_PRIORITY: assert property (take |-> (requests & ((8'h01 << winner[2:0]) - 8'h01)) == 8'h00)
        else $error("Lower-index request skipped.");

    COV_ENTRY: cover property (take ##5 pc_load_out);
    COV_RETURN_THEN_TAKE: cover property (returning ##[1:20] take);
    COV_GUARD_WINDOW: cover property (guard_open && |requests);
    COV_SLEEP_ENTRY: cover property (take && sleeping_in);

endmodule : cpu_interrupt_and_status_unit
`default_nettype wire

// file: rtl/irq_unit_params.svh
// Register offsets, field positions, reset values and cycle counts of the interrupt unit.
`ifndef IRQ_UNIT_PARAMS_SVH
`define IRQ_UNIT_PARAMS_SVH

`define IRQ_ENABLE_ADDR     6'h3A
`define IRQ_FLAG_ADDR       6'h3B
`define GUARD_ADDR          6'h3C
`define SP_LOW_ADDR         6'h3D
`define SP_HIGH_ADDR        6'h3E
`define FLAGS_ADDR          6'h3F

`define GUARD_SIGNATURE     8'hD8
`define GUARD_WINDOW_INSTR  3'h4

`define FLAG_GIE            7
`define FLAG_T              6
`define FLAG_H              5
`define FLAG_S              4
`define FLAG_V              3
`define FLAG_N              2
`define FLAG_Z              1
`define FLAG_C              0
`define FLAGS_RESET         8'h00
`define IRQ_REG_RESET       8'h00

`define ENTRY_CYCLES        4'h4
`define SLEEP_EXTRA_CYCLES  4'h4
`define RETURN_CYCLES       4'h4

`endif

// file: rtl/irq_unit_pkg.sv
// Types shared by the interrupt and status unit.
`default_nettype none
package irq_unit_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ENTRY,
        SEQ_RETURN
    } seq_state_e;
    typedef logic [7:0] byte_t;
endpackage : irq_unit_pkg
`default_nettype wire

// file: verification/stack_ram_model.sv
// Stack memory model that answers the unit's push and pop cycles.
`default_nettype none
module stack_ram_model (
    // Clock
    input  wire logic        clock_in,
    // Stack port
    input  wire logic        mem_wr_in,
    input  wire logic        mem_rd_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [7:0]  mem_wdata_in,
    output logic      [7:0]  mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:511];
    initial mem_rdata_out = 8'h00;
    // Outside a read cycle the data toggles, so a sample one cycle late sees the inverted byte.
    always @(posedge clock_in) begin
        if (mem_wr_in) begin
            mem[mem_addr_in[8:0]] <= mem_wdata_in;
        end
        mem_rdata_out <= mem_rd_in ? mem[mem_addr_in[8:0]] : ~mem_rdata_out;
    end
endmodule : stack_ram_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the interrupt and status unit.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in  = 1'b0;
    logic        reset_in  = 1'b1;
    logic [5:0]  io_addr   = 6'h00;
    logic        io_wr     = 1'b0;
    logic        io_rd     = 1'b0;
    logic [7:0]  io_wdata  = 8'h00;
    logic [7:0]  src_event = 8'h00;
    logic        done      = 1'b0;
    logic        set_op    = 1'b0;
    logic        clr_op    = 1'b0;
    logic        ret_op    = 1'b0;
    logic        push      = 1'b0;
    logic        alu_we    = 1'b0;
    logic [6:0]  alu_flags = 7'h00;
    logic [10:0] pc        = 11'h000;
    logic [7:0]  rdata;
    logic        pc_load;
    logic [10:0] pc_value;
    logic        mem_wr;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic        wr_ok;
    logic        rd_seen   = 1'b0;
    logic        sleeping  = 1'b0;
    logic [7:0]  src_level = 8'h00;
    logic        call_push = 1'b0;
    logic        ret_pop   = 1'b0;
    logic        pop       = 1'b0;
    logic        irq_ack;
    logic        busy;
    logic [7:0]  flags_out;
    logic [15:0] sp_out;
    int          acks      = 0;
    int          err_total = 0;
    int          tests_run = 0;
    logic [15:0] rd_q[$];
    logic [15:0] pc_q[$];

    always #2.5 clock_in = ~clock_in;

    cpu_interrupt_and_status_unit #(.LEVEL_MASK(8'h80)) u_cpu_interrupt_and_status_unit (
        .clock_in(clock_in), .reset_in(reset_in), .io_addr_in(io_addr), .io_wr_in(io_wr),
        .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(rdata),
        .src_event_in(src_event), .src_level_in(src_level), .instr_done_in(done),
        .global_irq_set_op_in(set_op), .global_irq_clear_op_in(clr_op),
        .return_from_irq_op_in(ret_op), .sleeping_in(sleeping), .pc_in(pc),
        .call_push_in(call_push), .ret_pop_in(ret_pop), .byte_push_in(push), .byte_pop_in(pop),
        .alu_flags_we_in(alu_we), .alu_flags_in(alu_flags), .irq_ack_out(irq_ack),
        .seq_busy_out(busy), .pc_load_out(pc_load), .pc_value_out(pc_value),
        .mem_wr_out(mem_wr), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
        .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
        .protected_write_ok_out(wr_ok), .core_flags_out(flags_out), .stack_pointer_out(sp_out)
    );

    stack_ram_model u_stack_ram_model (
        .clock_in(clock_in), .mem_wr_in(mem_wr), .mem_rd_in(mem_rd),
        .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata), .mem_rdata_out(mem_rdata)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // A read notes its expected byte in the queue for the monitor.
    task automatic io(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_in);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= wr;
        io_rd    <= !wr;
        if (!wr) rd_q.push_back({8'h00, d});
        @(posedge clock_in);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask : io

    // Sequencer pulse {done, set, clear, return, push}, then room for a full sequence.
    task automatic pulse(input logic [4:0] p);
        @(posedge clock_in);
        {done, set_op, clr_op, ret_op, push} <= p;
        @(posedge clock_in);
        {done, set_op, clr_op, ret_op, push} <= 5'h00;
        repeat (6) @(posedge clock_in);
    endtask : pulse

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    always @(posedge clock_in) begin
        if (rd_seen) check({8'h00, rdata}, rd_q.pop_front());
        if (pc_load) check({5'h00, pc_value}, pc_q.pop_front());
        if (pc_load) check({15'h0000, busy}, 16'h0000);
        if (irq_ack) check({15'h0000, busy}, 16'h0001);
        if (irq_ack) acks++;
        rd_seen <= io_rd;
    end

    initial begin
        #20000;
        err_total++;
        close_out();
    end

    initial begin
        void'($urandom(32'h033bdcbc));
        repeat (12) @(posedge clock_in);
        reset_in <= 1'b0;
        io(1'b0, 6'h3F, 8'h00);
        io(1'b0, 6'h3D, 8'h3F);
        io(1'b1, 6'h3E, 8'h55);
        io(1'b0, 6'h3E, 8'h01);
        $display("test reset_values done");
        io(1'b1, 6'h3A, 8'h05);
        @(posedge clock_in);
        src_event <= 8'h05;
        alu_we    <= 1'b1;
        alu_flags <= 7'h05;
        pc        <= 11'($urandom());
        @(posedge clock_in);
        src_event <= 8'h00;
        alu_we    <= 1'b0;
        io(1'b0, 6'h3F, 8'h15);
        io(1'b0, 6'h3B, 8'h05);
        pulse(5'b01000);
        pc_q.push_back(16'h0001);
        pulse(5'b10000);
        io(1'b0, 6'h3B, 8'h04);
        io(1'b0, 6'h3F, 8'h15);
        io(1'b0, 6'h3D, 8'h3D);
        $display("test entry done");
        pc_q.push_back({5'h00, pc});
        pulse(5'b00010);
        io(1'b0, 6'h3F, 8'h95);
        io(1'b0, 6'h3D, 8'h3F);
        $display("test return done");
        pulse(5'b10100);
        io(1'b0, 6'h3B, 8'h04);
        io(1'b0, 6'h3F, 8'h15);
        io(1'b1, 6'h3B, 8'h04);
        io(1'b0, 6'h3B, 8'h00);
        pulse(5'b00001);
        io(1'b0, 6'h3D, 8'h3E);
        $display("test clear_and_push done");
        pulse(5'b01000);
        @(posedge clock_in);
        src_event <= 8'h01;
        @(posedge clock_in);
        src_event <= 8'h00;
        io(1'b1, 6'h3C, 8'hD8);
        @(posedge clock_in);
        check({15'h0000, wr_ok}, 16'h0001);
        io(1'b0, 6'h3C, 8'h01);
        repeat (4) pulse(5'b10000);
        check({15'h0000, wr_ok}, 16'h0000);
        io(1'b0, 6'h3C, 8'h00);
        pc_q.push_back(16'h0001);
        pulse(5'b10000);
        $display("test guard_window done");
        check(16'(pc_q.size()), 16'h0000);
        pulse(5'b01000);
        @(posedge clock_in);
        sleeping  <= 1'b1;
        src_event <= 8'h04;
        @(posedge clock_in);
        src_event <= 8'h00;
        pc_q.push_back(16'h0003);
        pulse(5'b10000);
        repeat (3) @(posedge clock_in);
        sleeping <= 1'b0;
        $display("test sleep_entry done");
        pulse(5'b01000);
        src_level <= 8'h80;
        pulse(5'b10000);
        src_level <= 8'h00;
        io(1'b1, 6'h3A, 8'h85);
        pulse(5'b10000);
        src_level <= 8'h80;
        pc_q.push_back(16'h0008);
        pulse(5'b10000);
        src_level <= 8'h00;
        check(16'(pc_q.size()), 16'h0000);
        $display("test level_source done");
        @(posedge clock_in);
        call_push <= 1'b1;
        @(posedge clock_in);
        call_push <= 1'b0;
        io(1'b0, 6'h3D, 8'h36);
        @(posedge clock_in);
        ret_pop <= 1'b1;
        @(posedge clock_in);
        ret_pop <= 1'b0;
        pop     <= 1'b1;
        @(posedge clock_in);
        pop <= 1'b0;
        io(1'b0, 6'h3D, 8'h39);
        check(sp_out, 16'h0139);
        check({8'h00, flags_out}, 16'h0015);
        check(16'(acks), 16'h0004);
        $display("test stack_ops done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
